/* File: src/flash_erase_device.sv */
// Device end: erase command decode, checks and self-timed erase
`timescale 1ns/1ps
module flash_erase_device (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Link
    flash_link_if.device link,
    // Protection and fault inputs
    input wire logic [2:0] region_protect_field,
    input wire logic lock_scheme_select,
    input wire logic block_locked,
    input wire logic erase_fault,
    // Status
    output logic busy_flag,
    output logic write_latch_flag,
    output logic erase_error_flag,
    output logic program_error_flag,
    output logic [7:0] first_status_register,
    output logic erase_start,
    output logic [23:0] erase_addr,
    output logic [1:0] erase_kind
);
    typedef enum {ST_IDLE, ST_ERASE} erase_state_e;
    logic cs_s, sck_s, si_s, sck_prev_q, cs_prev_q;
    logic [5:0] bitcnt_q;
    logic [7:0] op_q;
    logic [23:0] addr_q;
    logic poll_q;
    logic [15:0] cnt_q;
    erase_state_e st_q;
    logic so_q;
    logic rise, frame_end, is_page, is_blk, is_chip, protect_hit, whole, any_erase;
    logic [23:0] mask;

    // Select idles high; a low reset value would fake a frame end after reset
    sync2 #(.RESET_LEVEL(1'b1)) u_cs (.clk(clk), .resetn(resetn), .d(link.cs_n), .q(cs_s));
    sync2 u_sck (.clk(clk), .resetn(resetn), .d(link.sck), .q(sck_s));
    sync2 u_si (.clk(clk), .resetn(resetn), .d(link.si), .q(si_s));

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sck_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            cs_prev_q <= cs_s;
        end
    end
    assign rise = sck_s && !sck_prev_q && !cs_s;
    assign frame_end = cs_s && !cs_prev_q;

    // ----------------------------------------------------------------
    // Opcode and address shift, MSB first
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bitcnt_q <= 6'h00;
            op_q <= 8'h00;
            addr_q <= 24'h000000;
        end else if (cs_s) begin
            bitcnt_q <= 6'h00;
        end else if (rise) begin
            if (bitcnt_q != 6'h3F) begin
                bitcnt_q <= bitcnt_q + 6'h01;
            end
            if (bitcnt_q < 6'(flash_erase_pkg::OPCODE_BITS)) begin
                op_q <= {op_q[6:0], si_s};
            end else if (bitcnt_q < 6'(flash_erase_pkg::OPCODE_BITS
                                       + flash_erase_pkg::ADDR_BITS)) begin
                addr_q <= {addr_q[22:0], si_s};
            end
        end
    end

    assign is_page = op_q == flash_erase_pkg::OP_PAGE_A
        || op_q == flash_erase_pkg::OP_PAGE_B;
    assign is_blk = op_q == flash_erase_pkg::OP_BLK4 || op_q == flash_erase_pkg::OP_BLK32
        || op_q == flash_erase_pkg::OP_BLK64;
    assign is_chip = op_q == flash_erase_pkg::OP_CHIP_A
        || op_q == flash_erase_pkg::OP_CHIP_B;
    assign any_erase = is_page || is_blk || is_chip;
    // Partial byte never completes a frame
    assign whole = bitcnt_q[2:0] == 3'h0;
    assign protect_hit = is_chip ? (region_protect_field != 3'h0
        || (lock_scheme_select && block_locked))
        : (region_protect_field != 3'h0 || block_locked);

    always_comb begin
        case (op_q)
            flash_erase_pkg::OP_BLK4: mask = flash_erase_pkg::MASK_BLK4;
            flash_erase_pkg::OP_BLK32: mask = flash_erase_pkg::MASK_BLK32;
            flash_erase_pkg::OP_BLK64: mask = flash_erase_pkg::MASK_BLK64;
            default: mask = flash_erase_pkg::MASK_PAGE;
        endcase
    end

    // ----------------------------------------------------------------
    // Erase sequencer, latch and error flags
    // ----------------------------------------------------------------
    logic ok_len;
    assign ok_len = is_chip ? bitcnt_q == 6'(flash_erase_pkg::OPCODE_BITS)
        : bitcnt_q == 6'(flash_erase_pkg::OPCODE_BITS + flash_erase_pkg::ADDR_BITS);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= ST_IDLE;
            cnt_q <= flash_erase_pkg::CNT_ZERO;
            write_latch_flag <= 1'b0;
            erase_error_flag <= 1'b0;
            program_error_flag <= 1'b0;
            erase_start <= 1'b0;
            erase_addr <= 24'h000000;
            erase_kind <= 2'h0;
        end else begin
            erase_start <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (frame_end && whole && bitcnt_q == 6'h08
                        && op_q == flash_erase_pkg::OP_WREN) begin
                        write_latch_flag <= 1'b1;
                    end else if (frame_end && any_erase) begin
                        if (write_latch_flag && whole && ok_len && !protect_hit) begin
                            st_q <= ST_ERASE;
                            erase_start <= 1'b1;
                            erase_addr <= is_chip ? 24'h000000 : (addr_q & mask);
                            erase_kind <= is_chip ? 2'h2 : (is_blk ? 2'h1 : 2'h0);
                            cnt_q <= is_chip ? 16'(flash_erase_pkg::ARRAY_ERASE_CYCLES)
                                : is_blk ? 16'(flash_erase_pkg::BLOCK_ERASE_CYCLES)
                                : 16'(flash_erase_pkg::PAGE_ERASE_CYCLES);
                            erase_error_flag <= 1'b0;
                            program_error_flag <= 1'b0;
                        end else begin
                            // Refusal or abort, latch clear (no-op with latch already 0)
                            write_latch_flag <= 1'b0;
                        end
                    end
                end
                ST_ERASE: begin
                    // Suspend has no decode here, so chip erase runs through
                    cnt_q <= cnt_q - 16'h0001;
                    if (cnt_q == 16'(flash_erase_pkg::LATCH_CLEAR_CYCLE)) begin
                        write_latch_flag <= 1'b0;
                        if (erase_fault) begin
                            erase_error_flag <= 1'b1;
                            program_error_flag <= 1'b1;
                        end
                    end
                    if (cnt_q == flash_erase_pkg::CNT_ZERO) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
    assign busy_flag = st_q == ST_ERASE;
    assign first_status_register = {6'h00, write_latch_flag, busy_flag};

    // ----------------------------------------------------------------
    // Active status output after 25h
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            poll_q <= 1'b0;
            so_q <= 1'b0;
        end else begin
            if (cs_s) begin
                poll_q <= 1'b0;
            end else if (rise && bitcnt_q == 6'h07
                         && {op_q[6:0], si_s} == flash_erase_pkg::OP_STATUS_POLL) begin
                poll_q <= 1'b1;
            end
            so_q <= poll_q && busy_flag;
        end
    end
    assign link.so = so_q;
endmodule // flash_erase_device

/* File: src/flash_erase_pkg.sv */
// Constants shared by the erase command device end and host end
package flash_erase_pkg;
    // ----------------------------------------------------------------
    // Opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_PAGE_A = 8'h81;
    localparam logic [7:0] OP_PAGE_B = 8'hDB;
    localparam logic [7:0] OP_BLK4 = 8'h20;
    localparam logic [7:0] OP_BLK32 = 8'h52;
    localparam logic [7:0] OP_BLK64 = 8'hD8;
    localparam logic [7:0] OP_CHIP_A = 8'h60;
    localparam logic [7:0] OP_CHIP_B = 8'hC7;
    localparam logic [7:0] OP_STATUS_POLL = 8'h25;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    // ----------------------------------------------------------------
    // Frame layout and field positions
    // ----------------------------------------------------------------
    localparam int OPCODE_BITS = 8;
    localparam int ADDR_BITS = 24;
    localparam int PAGE_LSB = 8;
    localparam int PAGE_MSB = 18;
    localparam logic [23:0] MASK_PAGE = 24'h07FF00;
    localparam logic [23:0] MASK_BLK4 = 24'hFFF000;
    localparam logic [23:0] MASK_BLK32 = 24'hFF8000;
    localparam logic [23:0] MASK_BLK64 = 24'hFF0000;
    localparam int BUSY_BIT = 0;
    localparam int LATCH_BIT = 1;
    localparam logic [2:0] PROTECT_RESET = 3'h0;
    // ----------------------------------------------------------------
    // Erase timing, shortened for simulation
    // ----------------------------------------------------------------
    localparam int PAGE_ERASE_CYCLES = 64;
    localparam int BLOCK_ERASE_CYCLES = 128;
    localparam int ARRAY_ERASE_CYCLES = 256;
    localparam int LATCH_CLEAR_CYCLE = 1;
    localparam int LINK_DIV = 4;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
endpackage

/* File: src/flash_link_if.sv */
// Serial link between host controller and flash erase device
`timescale 1ns/1ps
interface flash_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    modport device (input cs_n, input sck, input si, output so);
    modport host (output cs_n, output sck, output si, input so);
endinterface

/* File: src/sync2.sv */
// Two flop synchroniser
`timescale 1ns/1ps
module sync2 #(
    parameter logic RESET_LEVEL = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Level
    input wire logic d,
    output logic q
);
    logic m_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            m_q <= RESET_LEVEL;
            q <= RESET_LEVEL;
        end else begin
            m_q <= d;
            q <= m_q;
        end
    end
endmodule // sync2

/* File: src/flash_erase_host.sv */
// Host end: sends one erase frame, optionally polls busy on serial out
`timescale 1ns/1ps
module flash_erase_host (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Link
    flash_link_if.host link,
    // Command request
    input wire logic req_valid,
    input wire logic [7:0] req_opcode,
    input wire logic [23:0] req_addr,
    input wire logic [5:0] req_bits,
    input wire logic req_poll,
    output logic req_ready,
    output logic done
);
    typedef enum {H_IDLE, H_SHIFT, H_POLL} host_state_e;
    host_state_e st_q;
    logic [31:0] sh_q;
    logic [5:0] left_q;
    logic [1:0] div_q;
    logic sck_q, cs_n_q, poll_q, so_s, so_prev_q, seen_q, watch_q;

    sync2 u_so (.clk(clk), .resetn(resetn), .d(link.so), .q(so_s));

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= H_IDLE;
            sh_q <= 32'h00000000;
            left_q <= 6'h00;
            div_q <= 2'h0;
            sck_q <= 1'b0;
            cs_n_q <= 1'b1;
            poll_q <= 1'b0;
            so_prev_q <= 1'b0;
            seen_q <= 1'b0;
            watch_q <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            so_prev_q <= so_s;
            div_q <= div_q + 2'h1;
            case (st_q)
                H_IDLE: begin
                    sck_q <= 1'b0;
                    if (req_valid) begin
                        // Opcode then address, MSB first
                        sh_q <= {req_opcode, req_addr};
                        left_q <= req_bits;
                        poll_q <= req_poll;
                        cs_n_q <= 1'b0;
                        div_q <= 2'h0;
                        st_q <= H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    if (div_q == 2'(flash_erase_pkg::LINK_DIV - 1)) begin
                        if (sck_q) begin
                            sck_q <= 1'b0;
                            sh_q <= {sh_q[30:0], 1'b0};
                        end else if (left_q == 6'h00) begin
                            cs_n_q <= 1'b1;
                            seen_q <= 1'b0;
                            st_q <= poll_q ? H_POLL : H_IDLE;
                            done <= !poll_q;
                        end else begin
                            sck_q <= 1'b1;
                            left_q <= left_q - 6'h01;
                        end
                    end
                end
                H_POLL: begin
                    // Poll frame: 25h then watch busy fall
                    if (cs_n_q) begin
                        // Select stays high a few clocks so the device sees the frame end
                        if (div_q == 2'(flash_erase_pkg::LINK_DIV - 1)) begin
                            sh_q <= {flash_erase_pkg::OP_STATUS_POLL, 24'h000000};
                            left_q <= 6'h08;
                            poll_q <= 1'b0;
                            watch_q <= 1'b1;
                            cs_n_q <= 1'b0;
                            st_q <= H_SHIFT;
                        end
                    end else begin
                        if (so_s) begin
                            seen_q <= 1'b1;
                        end
                        if (so_prev_q && !so_s && seen_q) begin
                            cs_n_q <= 1'b1;
                            st_q <= H_IDLE;
                            done <= 1'b1;
                        end
                    end
                end
                default: st_q <= H_IDLE;
            endcase
            if (st_q == H_SHIFT && left_q == 6'h00 && !sck_q && watch_q
                && div_q == 2'(flash_erase_pkg::LINK_DIV - 1)) begin
                cs_n_q <= 1'b0; // Keep select low while watching
                watch_q <= 1'b0;
                st_q <= H_POLL;
                done <= 1'b0;
            end
        end
    end
    assign req_ready = st_q == H_IDLE;
    assign link.cs_n = cs_n_q;
    assign link.sck = sck_q;
    assign link.si = sh_q[31];
endmodule // flash_erase_host

/* File: sim/flash_erase_sva.sv */
// Assertions on the erase link and the device status outputs
`timescale 1ns/1ps
module flash_erase_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Link
    input wire logic cs_n,
    input wire logic sck,
    input wire logic so,
    // Device status
    input wire logic busy_flag,
    input wire logic write_latch_flag,
    input wire logic erase_start
);
    // ------------------------------------------------------------
    // Helper logic and sequences
    // ------------------------------------------------------------
    localparam int BUSY_MAX = 300;
    logic [15:0] busy_cnt_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // Longest erase plus margin, so a stuck busy shows up quickly
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_cnt_q <= 16'h0000;
        end else begin
            busy_cnt_q <= busy_flag ? busy_cnt_q + 16'h0001 : 16'h0000;
        end
    end
    sequence poll_end;
        !cs_n && so && busy_flag ##1 !busy_flag;
    endsequence
    sequence start_seen;
        erase_start ##1 busy_flag;
    endsequence
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    start_idle_a: assert property (erase_start |-> cs_n && $past(cs_n))
        else $error("erase started while select low");
    start_latch_a: assert property (erase_start |-> $past(write_latch_flag))
        else $error("erase started without write latch");
    start_busy_a: assert property (erase_start |-> ##[0:1] busy_flag)
        else $error("busy missing after erase start");
    busy_hold_a: assert property (start_seen |=> busy_flag [*8])
        else $error("busy dropped early");
    latch_clear_a: assert property ($fell(busy_flag) |-> !write_latch_flag)
        else $error("write latch still set at erase end");
    quiet_start_a: assert property (erase_start |-> !$past(busy_flag, 4))
        else $error("erase restarted while busy");
    poll_fall_a: assert property (poll_end |-> ##[0:4] !so)
        else $error("serial out did not follow busy fall");
    so_busy_a: assert property (so |-> busy_flag || $past(busy_flag))
        else $error("serial out high while idle");
    busy_bound_a: assert property (busy_cnt_q <= BUSY_MAX)
        else $error("erase never finished");
    sck_idle_a: assert property (cs_n && $past(cs_n) |-> !sck)
        else $error("link clock runs outside frame");
endmodule // flash_erase_sva

/* File: sim/tb_top.sv */
// Self-checking bench: host end drives device end across the link
`timescale 1ns/1ps
module tb_top;
    // ------------------------------------------------------------
    // Signals, instances, tasks
    // ------------------------------------------------------------
    typedef struct {
        logic [7:0] op;
        logic [23:0] a;
        logic [5:0] b;
        logic w;
        logic [1:0] p;
        logic go;
        logic [1:0] k;
        logic [23:0] x;
    } row_s;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] prot = 3'h0;
    logic lock_sel = 1'b0;
    logic blk_lock = 1'b0;
    logic fault = 1'b0;
    logic req_valid = 1'b0;
    logic [7:0] req_opcode = 8'h00;
    logic [23:0] req_addr = 24'h000000;
    logic [5:0] req_bits = 6'h00;
    logic req_poll = 1'b0;
    logic req_ready, done, busy, latch, ee, pe, start;
    logic [7:0] sr1;
    logic [23:0] e_addr, st_addr;
    logic [1:0] e_kind, st_kind;
    int err_total = 0;
    int n_tests = 0;
    int n_start = 0;
    int n_so = 0;
    int k;
    row_s rows[15] = '{
        '{8'h81, 24'hFFFFFF, 6'h20, 1'h1, 2'h0, 1'h1, 2'h0, 24'h07FF00},
        '{8'hDB, 24'h123456, 6'h20, 1'h1, 2'h0, 1'h1, 2'h0, 24'h023400},
        '{8'h20, 24'hABCDEF, 6'h20, 1'h1, 2'h0, 1'h1, 2'h1, 24'hABC000},
        '{8'h52, 24'hABCDEF, 6'h20, 1'h1, 2'h0, 1'h1, 2'h1, 24'hAB8000},
        '{8'hD8, 24'hABCDEF, 6'h20, 1'h1, 2'h0, 1'h1, 2'h1, 24'hAB0000},
        '{8'h60, 24'h000000, 6'h08, 1'h1, 2'h0, 1'h1, 2'h2, 24'h000000},
        '{8'hC7, 24'h000000, 6'h08, 1'h1, 2'h0, 1'h1, 2'h2, 24'h000000},
        '{8'h20, 24'h001000, 6'h20, 1'h0, 2'h0, 1'h0, 2'h0, 24'h000000},
        '{8'h20, 24'h001000, 6'h20, 1'h1, 2'h2, 1'h0, 2'h0, 24'h000000},
        '{8'h81, 24'h000100, 6'h20, 1'h1, 2'h1, 1'h0, 2'h0, 24'h000000},
        '{8'h60, 24'h000000, 6'h08, 1'h1, 2'h1, 1'h0, 2'h0, 24'h000000},
        '{8'hD8, 24'h010000, 6'h10, 1'h1, 2'h0, 1'h0, 2'h0, 24'h000000},
        '{8'h20, 24'h001000, 6'h0D, 1'h1, 2'h0, 1'h0, 2'h0, 24'h000000},
        '{8'h81, 24'h000100, 6'h1D, 1'h1, 2'h0, 1'h0, 2'h0, 24'h000000},
        '{8'hC7, 24'h000000, 6'h0C, 1'h1, 2'h0, 1'h0, 2'h0, 24'h000000}};
    flash_link_if link ();
    flash_erase_device u_flash_erase_device (.clk(clk), .resetn(resetn), .link(link.device),
        .region_protect_field(prot), .lock_scheme_select(lock_sel), .block_locked(blk_lock),
        .erase_fault(fault), .busy_flag(busy), .write_latch_flag(latch), .erase_error_flag(ee),
        .program_error_flag(pe), .first_status_register(sr1), .erase_start(start),
        .erase_addr(e_addr), .erase_kind(e_kind));
    flash_erase_host u_flash_erase_host (.clk(clk), .resetn(resetn), .link(link.host),
        .req_valid(req_valid), .req_opcode(req_opcode), .req_addr(req_addr),
        .req_bits(req_bits), .req_poll(req_poll), .req_ready(req_ready), .done(done));
    flash_erase_sva u_flash_erase_sva (.clk(clk), .resetn(resetn), .cs_n(link.cs_n),
        .sck(link.sck), .so(link.so), .busy_flag(busy), .write_latch_flag(latch),
        .erase_start(start));
    initial begin
        forever #10 clk = ~clk;
    end
    // Sample on the falling edge, clear of the registers' own edge
    always @(negedge clk) begin
        if (start === 1'b1) begin
            n_start++;
            st_addr = e_addr;
            st_kind = e_kind;
        end
        if (link.so === 1'b1) n_so++;
    end
    task automatic chk_bit(input string what, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic chk_val(input string what, input logic [23:0] e, input logic [23:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wait_sig(ref logic s, input logic v);
        for (int n = 0; n < 2000 && s !== v; n++) @(negedge clk);
        if (s !== v) begin
            err_total++;
            $display("unexpected wait expected %b seen %b", v, s);
        end
    endtask
    task automatic send(input logic [7:0] op, input logic [23:0] a, input logic [5:0] b,
            input logic p);
        wait_sig(req_ready, 1'b1);
        @(posedge clk);
        req_valid <= 1'b1;
        req_opcode <= op;
        req_addr <= a;
        req_bits <= b;
        req_poll <= p;
        @(posedge clk);
        req_valid <= 1'b0;
        wait_sig(done, 1'b1);
        repeat (8) @(negedge clk);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #(20 * 40000);
        err_total++;
        end_of_test();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        chk_val("status", 24'h000000, {16'h0000, sr1});
        for (int i = 0; i < 15; i++) begin
            @(posedge clk);
            prot <= {2'h0, rows[i].p[1]};
            lock_sel <= rows[i].p[0];
            blk_lock <= rows[i].p[0];
            if (rows[i].w) send(flash_erase_pkg::OP_WREN, 24'h000000, 6'h08, 1'b0);
            if (rows[i].w) chk_bit("latch", 1'b1, latch);
            k = n_start;
            send(rows[i].op, rows[i].a, rows[i].b, 1'b0);
            chk_bit("start", rows[i].go, n_start != k);
            if (rows[i].go) begin
                chk_val("kind", {22'h000000, rows[i].k}, {22'h000000, st_kind});
                if (rows[i].k != 2'h2) chk_val("addr", rows[i].x, st_addr);
                chk_bit("busy", 1'b1, busy);
                wait_sig(busy, 1'b0);
            end
            chk_bit("latch", 1'b0, latch);
            $display("test %0d done", i);
        end
        // Status poll: host holds select low until serial out falls
        send(flash_erase_pkg::OP_WREN, 24'h000000, 6'h08, 1'b0);
        k = n_so;
        send(8'hD8, 24'h010000, 6'h20, 1'b1);
        chk_bit("so_seen", 1'b1, n_so != k);
        chk_bit("busy", 1'b0, busy);
        $display("test poll done");
        // Failed erase and a suspend that must be ignored
        @(posedge clk);
        fault <= 1'b1;
        send(flash_erase_pkg::OP_WREN, 24'h000000, 6'h08, 1'b0);
        send(8'hC7, 24'h000000, 6'h08, 1'b0);
        send(flash_erase_pkg::OP_SUSPEND, 24'h000000, 6'h08, 1'b0);
        chk_val("status", 24'h000003, {16'h0000, sr1});
        wait_sig(busy, 1'b0);
        chk_bit("latch", 1'b0, latch);
        chk_bit("erase_err", 1'b1, ee);
        chk_bit("prog_err", 1'b1, pe);
        @(posedge clk);
        fault <= 1'b0;
        $display("test fault done");
        // Reset in mid-run drops the latch and idles the link
        send(flash_erase_pkg::OP_WREN, 24'h000000, 6'h08, 1'b0);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (3) @(negedge clk);
        chk_bit("latch", 1'b0, latch);
        chk_bit("cs_n", 1'b1, link.cs_n);
        @(posedge clk);
        resetn <= 1'b1;
        send(flash_erase_pkg::OP_WREN, 24'h000000, 6'h08, 1'b0);
        chk_bit("latch", 1'b1, latch);
        chk_bit("busy", 1'b0, busy);
        $display("test reset done");
        end_of_test();
    end
endmodule // tb_top
